// ===== src/hbwu_pkg.sv
package hbwu_pkg;

	// Entry and thread counts
	localparam int          NUM_ENTRY      = 4;
	localparam int          NUM_THREAD     = 8;
	localparam int          THREAD_W       = 3;
	localparam int          AXI_ADDR_W     = 12;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_IB_ADDR    = 8'h30;
	localparam logic [7:0]  IDX_IB_CTL     = 8'h40;
	localparam logic [7:0]  IDX_DW_FIRST   = 8'h50;
	localparam logic [7:0]  IDX_DW_SECOND  = 8'h60;
	localparam logic [7:0]  IDX_DW_CTL     = 8'h70;
	localparam logic [7:0]  IDX_RW_MASK    = 8'h80;
	localparam logic [7:0]  IDX_RW_VALUE   = 8'h90;
	localparam logic [7:0]  IDX_RW_CTL     = 8'h9c;
	localparam logic [7:0]  IDX_CAUSE      = 8'h15;
	localparam logic [7:0]  IDX_CAUSE_DATA = 8'h16;
	localparam logic [7:0]  BANK_SPAN      = 8'h04;
	localparam int          IDX_LSB        = 2;
	localparam int          IDX_MSB        = 9;

	// Control register fields
	localparam int          CTL_EN_BIT     = 0;
	localparam int          CTL_SEL_BIT    = 1;
	localparam int          CTL_LOAD_BIT   = 2;
	localparam int          CTL_THR_LSB    = 16;
	localparam int          CTL_THR_MSB    = 23;
	localparam logic [31:0] IB_CTL_WMASK   = 32'h00ff0003;
	localparam logic [31:0] DW_CTL_WMASK   = 32'h00ff0007;
	localparam logic [31:0] RW_CTL_WMASK   = 32'h00ff0003;
	localparam logic [31:0] FULL_WMASK     = 32'hffffffff;
	localparam logic [31:0] CTL_RESET      = 32'h00000000;
	localparam logic [31:0] ADDR_RESET     = 32'h00000000;

	// Cause register fields and codes
	localparam int          CAUSE_CODE_LSB = 0;
	localparam int          CAUSE_THR_LSB  = 8;
	localparam int          CAUSE_IDX_LSB  = 16;
	localparam logic [31:0] CAUSE_WMASK    = 32'h0003ff07;
	localparam logic [2:0]  CAUSE_NONE     = 3'h0;
	localparam logic [2:0]  CAUSE_IBREAK   = 3'h3;
	localparam logic [2:0]  CAUSE_DWATCH   = 3'h4;
	localparam logic [2:0]  CAUSE_RWATCH   = 3'h5;

	// Bus responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// Pipeline reports
	typedef struct packed {
		logic                valid;
		logic [THREAD_W-1:0] thread;
		logic [31:0]         program_counter;
	} hbwu_fetch_t;

	typedef struct packed {
		logic                valid;
		logic                load;
		logic [THREAD_W-1:0] thread;
		logic [31:0]         addr;
	} hbwu_mem_t;

	typedef struct packed {
		logic                valid;
		logic [THREAD_W-1:0] thread;
		logic [31:0]         id;
	} hbwu_res_t;

endpackage

// ===== src/hbwu_unit.sv
`timescale 1ns/1ps

// Contract
// RL1: Compare executing thread PC with each breakpoint address; raise debug interrupt.
// RL2: Four independent instruction breakpoints, each with own address and control.
// RL3: Instruction control chooses allowed threads and the firing condition.
// RL4: Control bits 23:16 are a per-thread enable mask, reset zero.
// RL5: Instruction control bit 1: clear fires on equal, set on not equal.
// RL6: Control bit 0 enables the entry; clear never fires; resets zero.
// RL7: Four first comparison addresses for data watchpoints, consecutive bank.
// RL8: Four second comparison addresses for data watchpoints, separate bank.
// RL9: Each data watchpoint has its own control register in a bank.
// RL10: Data control bit 2 set triggers on loads meeting the address condition.
// RL11: Data control bit 1: clear needs both conditions, set needs either.
// RL12: Four 32-bit masks applied to resource identifiers before comparison.
// RL13: Four 32-bit resource comparison values in a consecutive bank.
// RL14: Each resource watchpoint has its own control register in a bank.
// RL15: Resource control bit 1: clear fires on condition A, set on B.
// RL16: Record cause code 3 instruction, 4 data, 5 resource.
// RL17: Record the 2-bit index of the firing entry, lowest index wins.
// RL18: Record the number of the triggering thread in an eight-bit field.
// RL19: Capture memory address on data hit, resource id on resource hit.
// RL20: Data condition A compares with first address, B with second.
// RL21: Resource conditions compare masked id with value: A equal, B unequal.
module hbwu_unit
	import hbwu_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire hbwu_fetch_t           fetch_in,
	input  wire hbwu_mem_t             mem_in,
	input  wire hbwu_res_t             res_in,
	output logic                       debug_irq
);

	// Register banks, one word per entry
	logic [31:0]           ib_addr_ff  [NUM_ENTRY], ib_ctl_ff    [NUM_ENTRY];
	logic [31:0]           dw_first_ff [NUM_ENTRY], dw_second_ff [NUM_ENTRY];
	logic [31:0]           dw_ctl_ff   [NUM_ENTRY], rw_ctl_ff    [NUM_ENTRY];
	logic [31:0]           rw_mask_ff  [NUM_ENTRY], rw_value_ff  [NUM_ENTRY];
	logic [31:0]           cause_ff, cause_data_ff;
	logic                  irq_ff;
	// Bus state
	logic                  aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
	logic [AXI_ADDR_W-1:0] awaddr_ff;
	logic [31:0]           wdata_ff, rdata_ff;
	logic [3:0]            wstrb_ff;
	logic [1:0]            bresp_ff, rresp_ff;
	// Match results
	logic [NUM_ENTRY-1:0]  ib_hit, dw_hit, rw_hit;
	logic                  wr_fire, wr_ok, rd_ok;
	logic [7:0]            wr_idx, rd_idx;
	logic [31:0]           rd_data;
	logic [2:0]            nxt_code;
	logic [1:0]            nxt_entry;
	logic [THREAD_W-1:0]   nxt_thread;

	// True when idx falls in the four-entry bank at base
	function automatic logic in_bank(input logic [7:0] idx, input logic [7:0] base);
		in_bank = (idx >= base) && (idx < 8'(base + BANK_SPAN));
	endfunction
	// Byte-lane merge; reserved bits stay zero via wmask
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] wmask);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		merge = merge & wmask;
	endfunction
	// Lowest set bit index
	function automatic logic [1:0] lowest(input logic [NUM_ENTRY-1:0] v);
		lowest = 2'h0;
		for (int k = NUM_ENTRY - 1; k >= 0; k--) begin
			if (v[k]) begin
				lowest = 2'(k);
			end
		end
	endfunction

	// Per-entry comparators
	generate
		for (genvar i = 0; i < NUM_ENTRY; i++) begin : g_entry
			logic        ib_cond, dw_a, dw_b, dw_kind, dw_cond, rw_cond;
			logic [31:0] rw_masked;
			// RL5: equal or unequal select
			assign ib_cond = ib_ctl_ff[i][CTL_SEL_BIT]
				? (fetch_in.program_counter != ib_addr_ff[i])
				: (fetch_in.program_counter == ib_addr_ff[i]);
			// RL1: breakpoint fires on PC
			// RL6: enable gates firing
			// RL4: thread mask gates firing
			assign ib_hit[i] = fetch_in.valid && ib_ctl_ff[i][CTL_EN_BIT]
				&& ib_ctl_ff[i][CTL_THR_LSB + fetch_in.thread] && ib_cond;
			// RL20: range bounds as conditions
			assign dw_a = mem_in.addr >= dw_first_ff[i];
			assign dw_b = mem_in.addr <= dw_second_ff[i];
			// RL10: load or store select
			assign dw_kind = dw_ctl_ff[i][CTL_LOAD_BIT] ? mem_in.load : !mem_in.load;
			// RL11: AND or OR combine
			assign dw_cond = dw_ctl_ff[i][CTL_SEL_BIT] ? (dw_a || dw_b) : (dw_a && dw_b);
			// RL6: data enable and mask
			assign dw_hit[i] = mem_in.valid && dw_ctl_ff[i][CTL_EN_BIT]
				&& dw_ctl_ff[i][CTL_THR_LSB + mem_in.thread] && dw_kind && dw_cond;
			// RL21: masked identifier compare
			assign rw_masked = res_in.id & rw_mask_ff[i];
			// RL15: condition A or B
			assign rw_cond = rw_ctl_ff[i][CTL_SEL_BIT]
				? (rw_masked != rw_value_ff[i]) : (rw_masked == rw_value_ff[i]);
			// RL6: resource enable and mask
			assign rw_hit[i] = res_in.valid && rw_ctl_ff[i][CTL_EN_BIT]
				&& rw_ctl_ff[i][CTL_THR_LSB + res_in.thread] && rw_cond;
		end
	endgenerate

	// Cause selection; instruction beats data beats resource
	always_comb begin
		nxt_code   = CAUSE_NONE;
		nxt_entry  = 2'h0;
		nxt_thread = '0;
		// RL16: cause codes
		// RL17: lowest index wins
		if (|ib_hit) begin
			nxt_code   = CAUSE_IBREAK;
			nxt_entry  = lowest(ib_hit);
			nxt_thread = fetch_in.thread;
		end else if (|dw_hit) begin
			nxt_code   = CAUSE_DWATCH;
			nxt_entry  = lowest(dw_hit);
			nxt_thread = mem_in.thread;
		end else if (|rw_hit) begin
			nxt_code   = CAUSE_RWATCH;
			nxt_entry  = lowest(rw_hit);
			nxt_thread = res_in.thread;
		end
	end

	// Write channel handshakes; address and data taken in either order
	assign s_axi_awready = ce && !aw_held_ff && !bvalid_ff; // Frozen: nothing is lost
	assign s_axi_wready  = ce && !w_held_ff && !bvalid_ff;
	assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_idx        = awaddr_ff[IDX_MSB:IDX_LSB];
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	// Write decode; upper address bits must be zero
	always_comb begin
		wr_ok = 1'b0;
		if (awaddr_ff[AXI_ADDR_W-1:IDX_MSB+1] == '0) begin
			wr_ok = in_bank(wr_idx, IDX_IB_ADDR) || in_bank(wr_idx, IDX_IB_CTL)
				|| in_bank(wr_idx, IDX_DW_FIRST) || in_bank(wr_idx, IDX_DW_SECOND)
				|| in_bank(wr_idx, IDX_DW_CTL) || in_bank(wr_idx, IDX_RW_MASK)
				|| in_bank(wr_idx, IDX_RW_VALUE) || in_bank(wr_idx, IDX_RW_CTL)
				|| wr_idx == IDX_CAUSE || wr_idx == IDX_CAUSE_DATA;
		end
	end

	// Write address and data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// Write response; unmapped writes answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Comparator register banks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_ENTRY; i++) begin
				ib_addr_ff[i]   <= ADDR_RESET;
				ib_ctl_ff[i]    <= CTL_RESET;
				dw_first_ff[i]  <= ADDR_RESET;
				dw_second_ff[i] <= ADDR_RESET;
				dw_ctl_ff[i]    <= CTL_RESET;
				rw_mask_ff[i]   <= ADDR_RESET;
				rw_value_ff[i]  <= ADDR_RESET;
				rw_ctl_ff[i]    <= CTL_RESET;
			end
		end else if (ce && wr_fire && wr_ok) begin
			for (int i = 0; i < NUM_ENTRY; i++) begin
				// RL2: separate instruction address and control
				if (wr_idx == 8'(IDX_IB_ADDR + i)) begin
					ib_addr_ff[i] <= merge(ib_addr_ff[i], wdata_ff, wstrb_ff, FULL_WMASK);
				end
				// RL3: thread mask and condition stored
				if (wr_idx == 8'(IDX_IB_CTL + i)) begin
					ib_ctl_ff[i] <= merge(ib_ctl_ff[i], wdata_ff, wstrb_ff, IB_CTL_WMASK);
				end
				// RL7: first address bank
				if (wr_idx == 8'(IDX_DW_FIRST + i)) begin
					dw_first_ff[i] <= merge(dw_first_ff[i], wdata_ff, wstrb_ff, FULL_WMASK);
				end
				// RL8: second address bank
				if (wr_idx == 8'(IDX_DW_SECOND + i)) begin
					dw_second_ff[i] <= merge(dw_second_ff[i], wdata_ff, wstrb_ff, FULL_WMASK);
				end
				// RL9: data control bank
				if (wr_idx == 8'(IDX_DW_CTL + i)) begin
					dw_ctl_ff[i] <= merge(dw_ctl_ff[i], wdata_ff, wstrb_ff, DW_CTL_WMASK);
				end
				// RL12: resource mask bank
				if (wr_idx == 8'(IDX_RW_MASK + i)) begin
					rw_mask_ff[i] <= merge(rw_mask_ff[i], wdata_ff, wstrb_ff, FULL_WMASK);
				end
				// RL13: resource value bank
				if (wr_idx == 8'(IDX_RW_VALUE + i)) begin
					rw_value_ff[i] <= merge(rw_value_ff[i], wdata_ff, wstrb_ff, FULL_WMASK);
				end
				// RL14: resource control bank
				if (wr_idx == 8'(IDX_RW_CTL + i)) begin
					rw_ctl_ff[i] <= merge(rw_ctl_ff[i], wdata_ff, wstrb_ff, RW_CTL_WMASK);
				end
			end
		end
	end

	// Cause capture; a hit wins over a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_ff <= '0;
		end else if (ce) begin
			if (nxt_code != CAUSE_NONE) begin
				cause_ff <= '0;
				// RL16: record cause code
				cause_ff[CAUSE_CODE_LSB +: 3] <= nxt_code;
				// RL17: record entry index
				cause_ff[CAUSE_IDX_LSB +: 2] <= nxt_entry;
				// RL18: record thread number
				cause_ff[CAUSE_THR_LSB +: THREAD_W] <= nxt_thread;
			end else if (wr_fire && wr_ok && wr_idx == IDX_CAUSE) begin
				cause_ff <= merge(cause_ff, wdata_ff, wstrb_ff, CAUSE_WMASK);
			end
		end
	end

	// Address or identifier behind the last watchpoint hit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_data_ff <= '0;
		end else if (ce) begin
			// RL19: effective address or resource id
			if (nxt_code == CAUSE_DWATCH) begin
				cause_data_ff <= mem_in.addr;
			end else if (nxt_code == CAUSE_RWATCH) begin
				cause_data_ff <= res_in.id;
			end else if (wr_fire && wr_ok && wr_idx == IDX_CAUSE_DATA) begin
				cause_data_ff <= merge(cause_data_ff, wdata_ff, wstrb_ff, FULL_WMASK);
			end
		end
	end

	// Debug interrupt pulse, one cycle per hit cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ff <= 1'b0;
		end else if (ce) begin
			// RL1: interrupt to the core
			irq_ff <= (nxt_code != CAUSE_NONE);
		end
	end
	assign debug_irq = irq_ff;

	// Read decode; bank entry picked by low index bits
	assign rd_idx = s_axi_araddr[IDX_MSB:IDX_LSB];
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = '0;
		if (s_axi_araddr[AXI_ADDR_W-1:IDX_MSB+1] != '0) begin
			rd_ok = 1'b0;
		end else if (in_bank(rd_idx, IDX_IB_ADDR)) begin
			rd_data = ib_addr_ff[rd_idx[1:0]];
		end else if (in_bank(rd_idx, IDX_IB_CTL)) begin
			rd_data = ib_ctl_ff[rd_idx[1:0]];
		end else if (in_bank(rd_idx, IDX_DW_FIRST)) begin
			rd_data = dw_first_ff[rd_idx[1:0]];
		end else if (in_bank(rd_idx, IDX_DW_SECOND)) begin
			rd_data = dw_second_ff[rd_idx[1:0]];
		end else if (in_bank(rd_idx, IDX_DW_CTL)) begin
			rd_data = dw_ctl_ff[rd_idx[1:0]];
		end else if (in_bank(rd_idx, IDX_RW_MASK)) begin
			rd_data = rw_mask_ff[rd_idx[1:0]];
		end else if (in_bank(rd_idx, IDX_RW_VALUE)) begin
			rd_data = rw_value_ff[rd_idx[1:0]];
		end else if (in_bank(rd_idx, IDX_RW_CTL)) begin
			rd_data = rw_ctl_ff[2'(rd_idx - IDX_RW_CTL)];
		end else if (rd_idx == IDX_CAUSE) begin
			rd_data = cause_ff;
		end else if (rd_idx == IDX_CAUSE_DATA) begin
			rd_data = cause_data_ff;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read channel; one read outstanding
	assign s_axi_arready = ce && !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_data;
				rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

endmodule

// ===== tb/hbwu_unit_assertions.sv
`timescale 1ns/1ps
module hbwu_unit_assertions
	import hbwu_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire hbwu_fetch_t fetch_in,
	input wire hbwu_mem_t   mem_in,
	input wire hbwu_res_t   res_in,
	input wire logic        debug_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Address and data of one write taken at the same edge
	sequence wr_both;
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	// Interrupt only after a reported event
	chk_irq_cause: assert property (debug_irq |-> $past(ce && (fetch_in.valid || mem_in.valid || res_in.valid)))
		else $error("debug interrupt without a pipeline report");
	chk_irq_idle: assert property (ce && !fetch_in.valid && !mem_in.valid && !res_in.valid |=> !debug_irq)
		else $error("debug interrupt while pipeline idle");
	// Bus answers arrive on the documented edge
	chk_wr_answer: assert property (wr_both ##1 ce |=> s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	// Responses stand until taken; a taken write response goes
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_b_done: assert property (ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	chk_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted before response taken");
endmodule

// ===== tb/hbwu_core_model.sv
`timescale 1ns/1ps
module hbwu_core_model
	import hbwu_pkg::*;
(
	input wire logic aclk,
	output hbwu_fetch_t fetch_in,
	output hbwu_mem_t   mem_in,
	output hbwu_res_t   res_in
);
	// Quiet pipeline at start
	initial begin
		fetch_in = '0;
		mem_in = '0;
		res_in = '0;
	end

	// One report per selected stream, held for exactly one cycle
	task automatic issue(input logic [2:0] which, input logic [THREAD_W-1:0] t,
		input logic [31:0] v, input logic ld);
		if (which[0]) fetch_in <= '{1'b1, t, v};
		if (which[1]) mem_in <= '{1'b1, ld, t, v};
		if (which[2]) res_in <= '{1'b1, t, v};
		@(posedge aclk);
		// Stale fields inverted so they cannot pass for a hit
		fetch_in <= '{1'b0, ~t, ~v};
		mem_in <= '{1'b0, ~ld, ~t, ~v};
		res_in <= '{1'b0, ~t, ~v};
	endtask
endmodule

// ===== tb/hbwu_unit_bench.sv
`timescale 1ns/1ps
module hbwu_unit_bench import hbwu_pkg::*;;
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic                  ce = 1'b1;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0]           s_axi_wdata = '0;
	logic [3:0]            s_axi_wstrb = 4'hf;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                  s_axi_arready, s_axi_rvalid, debug_irq;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic [31:0]           s_axi_rdata;
	hbwu_fetch_t           fetch_in;
	hbwu_mem_t             mem_in;
	hbwu_res_t             res_in;
	int                    miscompares = 0, comparisons = 0, cyc = 0;
	logic [7:0]            bk [8] = '{IDX_IB_ADDR, IDX_IB_CTL, IDX_DW_FIRST, IDX_DW_SECOND,
		IDX_DW_CTL, IDX_RW_MASK, IDX_RW_VALUE, IDX_RW_CTL};
	logic [31:0]           wm [8] = '{FULL_WMASK, IB_CTL_WMASK, FULL_WMASK, FULL_WMASK,
		DW_CTL_WMASK, FULL_WMASK, FULL_WMASK, RW_CTL_WMASK};

	// 20 MHz clock
	always #25 aclk = ~aclk;

	hbwu_unit dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_in, .mem_in, .res_in, .debug_irq);
	hbwu_core_model core (.aclk, .fetch_in, .mem_in, .res_in);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Write one word; response taken a cycle late to exercise the stall
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		chk("bresp", 32'(s_axi_bresp), 32'(er));
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Read one word, also with a late ready
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		chk("rdata", s_axi_rdata, exp);
		chk("rresp", 32'(s_axi_rresp), 32'(er));
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	function automatic logic [31:0] cz(input logic [2:0] code, input int i, input int t);
		return {14'h0, 2'(i), 5'h0, 3'(t), 5'h0, code};
	endfunction

	// Clear the record, send one report, check pulse and record
	task automatic hit(input logic [2:0] which, input int t, input logic [31:0] v, input logic ld,
		input logic [31:0] ec, input logic [31:0] ed);
		wr(IDX_CAUSE, '0);
		wr(IDX_CAUSE_DATA, '0);
		core.issue(which, 3'(t), v, ld);
		#1;
		chk("irq", 32'(debug_irq), 32'(ec != '0));
		@(posedge aclk);
		#1;
		chk("irq_end", 32'(debug_irq), '0);
		@(posedge aclk);
		rd(IDX_CAUSE, ec);
		rd(IDX_CAUSE_DATA, ed);
	endtask

	task automatic s_regs();
		logic [7:0]  a;
		logic [31:0] d;
		rd(IDX_CAUSE, '0);
		for (int p = 0; p < 2; p++)
			for (int b = 0; b < 8; b++)
				for (int i = 0; i < 4; i++) begin
					a = bk[b] + 8'(i);
					d = ~32'(b * 4 + i);
					if (p == 0) begin
						rd(a, '0);
						wr(a, d);
					end else begin
						rd(a, d & wm[b]);
						wr(a, '0);
					end
				end
		// Unmapped places refuse with an error code
		wr(8'h00, 32'h1, RESP_SLVERR);
		rd(8'h34, '0, RESP_SLVERR);
	endtask

	task automatic s_instr();
		logic [31:0] pc;
		logic [31:0] m;
		for (int i = 0; i < 4; i++) begin
			pc = 32'h1000 + 32'(i * 4);
			m = 32'h1 << (18 + i);
			wr(IDX_IB_ADDR + 8'(i), pc);
			wr(IDX_IB_CTL + 8'(i), m | 32'h1);
			hit(3'h1, i + 2, pc, 1'b0, cz(CAUSE_IBREAK, i, i + 2), '0);
			hit(3'h1, i + 3, pc, 1'b0, '0, '0);
			hit(3'h1, i + 2, pc + 32'h4, 1'b0, '0, '0);
			wr(IDX_IB_CTL + 8'(i), m | 32'h3);
			hit(3'h1, i + 2, pc + 32'h4, 1'b0, cz(CAUSE_IBREAK, i, i + 2), '0);
			hit(3'h1, i + 2, pc, 1'b0, '0, '0);
			wr(IDX_IB_CTL + 8'(i), m | 32'h2);
			hit(3'h1, i + 2, pc + 32'h4, 1'b0, '0, '0);
		end
	endtask

	task automatic s_data();
		logic [31:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 32'h1 << (23 - i);
			wr(IDX_DW_FIRST + 8'(i), 32'h2000);
			wr(IDX_DW_SECOND + 8'(i), 32'h20ff);
			wr(IDX_DW_CTL + 8'(i), m | 32'h5);
			hit(3'h2, 7 - i, 32'h2010, 1'b1, cz(CAUSE_DWATCH, i, 7 - i), 32'h2010);
			hit(3'h2, 7 - i, 32'h2010, 1'b0, '0, '0);
			hit(3'h2, 7 - i, 32'h3000, 1'b1, '0, '0);
			wr(IDX_DW_CTL + 8'(i), m | 32'h7);
			hit(3'h2, 7 - i, 32'h3000, 1'b1, cz(CAUSE_DWATCH, i, 7 - i), 32'h3000);
			wr(IDX_DW_CTL + 8'(i), '0);
		end
	endtask

	task automatic s_res();
		logic [31:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 32'h1 << (16 + i);
			wr(IDX_RW_MASK + 8'(i), 32'h0000ffff);
			wr(IDX_RW_VALUE + 8'(i), 32'h00001234);
			wr(IDX_RW_CTL + 8'(i), m | 32'h1);
			hit(3'h4, i, 32'habcd1234, 1'b0, cz(CAUSE_RWATCH, i, i), 32'habcd1234);
			hit(3'h4, i, 32'h00001235, 1'b0, '0, '0);
			wr(IDX_RW_CTL + 8'(i), m | 32'h3);
			hit(3'h4, i, 32'h00001235, 1'b0, cz(CAUSE_RWATCH, i, i), 32'h00001235);
			wr(IDX_RW_CTL + 8'(i), '0);
		end
	endtask

	// All three classes hit at once; lowest index of the first class wins
	task automatic s_prio();
		wr(IDX_IB_ADDR + 8'h2, 32'h4000);
		wr(IDX_IB_ADDR + 8'h3, 32'h4000);
		wr(IDX_IB_CTL + 8'h2, 32'h00020001);
		wr(IDX_IB_CTL + 8'h3, 32'h00020001);
		wr(IDX_DW_FIRST, 32'h4000);
		wr(IDX_DW_SECOND, 32'h4000);
		wr(IDX_DW_CTL, 32'h00020005);
		wr(IDX_RW_MASK, FULL_WMASK);
		wr(IDX_RW_VALUE, 32'h4000);
		wr(IDX_RW_CTL, 32'h00020001);
		hit(3'h7, 1, 32'h4000, 1'b1, cz(CAUSE_IBREAK, 2, 1), '0);
		wr(IDX_IB_CTL + 8'h2, '0);
		wr(IDX_IB_CTL + 8'h3, '0);
		hit(3'h7, 1, 32'h4000, 1'b1, cz(CAUSE_DWATCH, 0, 1), 32'h4000);
		wr(IDX_DW_CTL, '0);
		hit(3'h7, 1, 32'h4000, 1'b1, cz(CAUSE_RWATCH, 0, 1), 32'h4000);
	endtask

	// Frozen clock enable; a matching resource report must leave no trace
	task automatic s_freeze();
		wr(IDX_CAUSE, '0);
		ce <= 1'b0;
		core.issue(3'h4, 3'h1, 32'h4000, 1'b0);
		ce <= 1'b1;
		#1;
		chk("irq_frozen", 32'(debug_irq), '0);
		@(posedge aclk);
		rd(IDX_CAUSE, '0);
	endtask

	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			finish_test();
		end
	end

	// Reset, then every scenario in turn
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		s_regs();
		s_instr();
		s_data();
		s_res();
		s_prio();
		s_freeze();
		finish_test();
	end
endmodule

bind hbwu_unit hbwu_unit_assertions u_chk (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .fetch_in, .mem_in, .res_in,
	.debug_irq);
